// file: hdl/cbig_pkg.sv
package cbig_pkg;

  // register byte offsets on the apb window
  localparam logic [11:0] CBIG_OFF_TXIE   = 12'h000;
  localparam logic [11:0] CBIG_OFF_BIE    = 12'h004;
  localparam logic [11:0] CBIG_OFF_GRPEN  = 12'h008;
  localparam logic [11:0] CBIG_OFF_STAT   = 12'h00C;
  localparam logic [11:0] CBIG_OFF_CLR    = 12'h010;
  localparam logic [11:0] CBIG_OFF_IEN    = 12'h014;
  localparam logic [11:0] CBIG_OFF_MODE   = 12'h018;

  // transmit-buffer enable field, bits 4..2
  localparam int          CBIG_TXIE_LSB   = 2;
  localparam logic [7:0]  CBIG_TXIE_MASK  = 8'h1C;
  localparam logic [7:0]  CBIG_RESET8     = 8'h00;
  localparam logic [31:0] CBIG_ZERO32     = 32'h0000_0000;

  // group enable bits (same positions as peripheral enable three)
  localparam int          CBIG_GRP_TX_BIT = 4;
  localparam int          CBIG_GRP_RX_BIT = 1;

  // status / interrupt bit layout
  localparam int          CBIG_ST_TX      = 0;
  localparam int          CBIG_ST_RX      = 1;
  localparam int          CBIG_ST_W       = 2;

  typedef enum logic [1:0] {
    CBIG_MODE_LEGACY   = 2'b00,
    CBIG_MODE_ENH_ONE  = 2'b01,
    CBIG_MODE_ENH_TWO  = 2'b10
  } cbig_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cbig_apb_req_t;

  typedef struct packed {
    logic [2:0] tx_done;   // transmit buffers 2..0
    logic [5:0] prog_ev;   // programmable buffers 5..0
    logic [1:0] rx_ev;     // dedicated receive buffers 1..0
  } cbig_events_t;

  typedef struct packed {
    logic [2:0]          tx_buffer_interrupt_enable;
    logic [7:0]          buffer_interrupt_enable;
    logic [7:0]          peripheral_int_enable_three;
    logic [CBIG_ST_W-1:0] status;
    logic [CBIG_ST_W-1:0] ien;
    cbig_mode_t          mode;
    logic [31:0]         prdata;
  } cbig_state_t;

endpackage

// file: hdl/cbig_top.sv
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
// Function
// R1 - transmit enable register bits 7-5 and 1-0 ignore writes and read zero.
// R2 - transmit enable bits 4-2 enable buffers two, one, zero, reset to zero.
// R3 - both buffer enable registers exist and act only in enhanced mode 1 or 2.
// R4 - a transmit buffer interrupt needs its own enable and the group tx enable.
// R5 - buffer enable bits 7-2 enable programmable buffers five to zero.
// R6 - buffer enable bits 1-0 enable dedicated receive buffers one and zero.
// R7 - buffer enable interrupts pass only if group tx or group rx is set.
// R8 - unimplemented addresses read as zero.
// R9 - group tx enable cleared blocks all transmit buffer interrupts.
// R10 - group rx enable cleared blocks all receive buffer interrupts; the code still passes programmable buffer requests while group tx is set.
// R11 - shared tx flag is set when any transmit buffer finished sending.
// R12 - group requests are or of event and enable, then and with group enable.
module cbig_top
  import cbig_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // buffer events, one-cycle pulses from the protocol engine
  input  wire cbig_events_t events,
  // to processor interrupt logic
  output logic              group_tx_done_flag,
  output logic              group_rx_flag,
  output logic              tx_int_req,
  output logic              rx_int_req,
  output logic              irq
);

  cbig_state_t   st;
  cbig_state_t   next_st;
  cbig_apb_req_t req;

  logic       enh;
  logic       grp_tx_en;
  logic       grp_rx_en;
  logic       tx_any;
  logic       prog_any;
  logic       rx_any;
  logic [2:0] tx_masked;
  logic [5:0] prog_masked;
  logic [1:0] rx_masked;
  logic       wr;
  logic       rd;
  logic [CBIG_ST_W-1:0] ev_set;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign wr  = req.psel & req.penable & req.pwrite;
  assign rd  = req.psel & ~req.penable & ~req.pwrite;

  assign enh = (st.mode == CBIG_MODE_ENH_ONE) ||
               (st.mode == CBIG_MODE_ENH_TWO); // R3
  assign grp_tx_en = st.peripheral_int_enable_three[CBIG_GRP_TX_BIT];
  assign grp_rx_en = st.peripheral_int_enable_three[CBIG_GRP_RX_BIT];

  // per-buffer qualification
  assign tx_masked   = events.tx_done & st.tx_buffer_interrupt_enable; // R2
  assign prog_masked = events.prog_ev & st.buffer_interrupt_enable[7:2]; // R5
  assign rx_masked   = events.rx_ev & st.buffer_interrupt_enable[1:0]; // R6
  assign tx_any   = enh & (|tx_masked); // R12
  assign prog_any = enh & (|prog_masked); // R12
  assign rx_any   = enh & (|rx_masked); // R12

  // programmable buffers count toward the rx group, passed by either group enable
  assign tx_int_req = tx_any & grp_tx_en; // R4 R9
  assign rx_int_req = (rx_any & grp_rx_en) |
                      (prog_any & (grp_tx_en | grp_rx_en)); // R7 R10
  assign group_tx_done_flag = st.status[CBIG_ST_TX]; // R11
  assign group_rx_flag      = st.status[CBIG_ST_RX];
  assign irq     = |(st.status & st.ien);
  assign prdata  = st.prdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign ev_set[CBIG_ST_TX] = tx_int_req | (enh & (|events.tx_done)); // R11
  assign ev_set[CBIG_ST_RX] = rx_int_req;

  always_comb begin
    next_st = st;
    // set wins over clear
    if (wr && req.paddr == CBIG_OFF_CLR) begin
      next_st.status = st.status & ~req.pwdata[CBIG_ST_W-1:0];
    end
    next_st.status = next_st.status | ev_set;
    if (wr) begin
      unique case (req.paddr)
        CBIG_OFF_TXIE: begin
          if (enh) begin
            next_st.tx_buffer_interrupt_enable =
              req.pwdata[CBIG_TXIE_LSB +: 3]; // R1 R2 R3
          end
        end
        CBIG_OFF_BIE: begin
          if (enh) begin
            next_st.buffer_interrupt_enable = req.pwdata[7:0]; // R3 R5 R6
          end
        end
        CBIG_OFF_GRPEN: begin
          next_st.peripheral_int_enable_three = req.pwdata[7:0];
        end
        CBIG_OFF_IEN: begin
          next_st.ien = req.pwdata[CBIG_ST_W-1:0];
        end
        CBIG_OFF_MODE: begin
          next_st.mode = cbig_mode_t'(req.pwdata[1:0]);
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (req.paddr)
        CBIG_OFF_TXIE: begin
          next_st.prdata = enh ? {24'h00_0000, 3'b000,
            st.tx_buffer_interrupt_enable, 2'b00} : CBIG_ZERO32; // R1 R3
        end
        CBIG_OFF_BIE: begin
          next_st.prdata = enh ? {24'h00_0000,
            st.buffer_interrupt_enable} : CBIG_ZERO32; // R3
        end
        CBIG_OFF_GRPEN: begin
          next_st.prdata = {24'h00_0000, st.peripheral_int_enable_three};
        end
        CBIG_OFF_STAT: begin
          next_st.prdata = {30'h0000_0000, st.status};
        end
        CBIG_OFF_IEN: begin
          next_st.prdata = {30'h0000_0000, st.ien};
        end
        CBIG_OFF_MODE: begin
          next_st.prdata = {30'h0000_0000, st.mode};
        end
        default: begin
          next_st.prdata = CBIG_ZERO32; // R8
        end
      endcase
    end
    // leaving enhanced modes drops the per-buffer enables
    if (!enh) begin
      next_st.tx_buffer_interrupt_enable = 3'b000; // R3
      next_st.buffer_interrupt_enable    = CBIG_RESET8; // R3
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// file: dv/cbig_engine_model.sv
`timescale 1ns/100ps
module cbig_engine_model
  import cbig_pkg::*;
(
  // clock
  input  wire logic         mclk,
  // bench request in, completion pulses out
  input  wire cbig_events_t start,
  output cbig_events_t      events = '0
);
  always_ff @(posedge mclk) begin
    events <= start;
  end
endmodule

// file: dv/cbig_checker_assertions.sv
`timescale 1ns/100ps
module cbig_checker
  import cbig_pkg::*;
(
  // clock, reset and bus
  input wire logic         mclk,
  input wire logic         rstn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // events and requests
  input wire cbig_events_t events,
  input wire logic         group_tx_done_flag,
  input wire logic         group_rx_flag,
  input wire logic         tx_int_req,
  input wire logic         rx_int_req,
  input wire logic         irq
);
  wire any_tx = |events.tx_done;
  wire any_rx = |{events.prog_ev, events.rx_ev};
  wire clr_wr = psel && penable && pwrite &&
                paddr == CBIG_OFF_CLR && pwdata[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_tx_clear;
    clr_wr && !any_tx;
  endsequence
  a_access_clean: assert property (psel && penable |-> pready && !pslverr)
    else $error("access phase not clean");
  a_tx_req_cause: assert property (tx_int_req |-> any_tx)
    else $error("tx request without event");
  a_rx_req_cause: assert property (rx_int_req |-> any_rx)
    else $error("rx request without event");
  a_tx_flag_set: assert property (tx_int_req |=> group_tx_done_flag)
    else $error("tx flag not set");
  a_rx_flag_set: assert property (rx_int_req |=> group_rx_flag)
    else $error("rx flag not set");
  a_tx_flag_cause: assert property (
    $rose(group_tx_done_flag) |-> $past(any_tx))
    else $error("tx flag rose without event");
  a_tx_flag_hold: assert property (
    group_tx_done_flag && !clr_wr |=> group_tx_done_flag)
    else $error("tx flag dropped");
  a_tx_flag_clear: assert property (s_tx_clear |=> !group_tx_done_flag)
    else $error("tx flag not cleared");
  a_irq_source: assert property (irq |-> group_tx_done_flag || group_rx_flag)
    else $error("irq without flag");
endmodule

// file: dv/cbig_tb_top.sv
`timescale 1ns/100ps
module cbig_tb_top;
  import cbig_pkg::*;
  logic         mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, q;
  logic         pready, pslverr, gtx, grx, txr, rxr, irq;
  cbig_events_t start = '0, events;
  int           mismatches = 0, n_tests = 0;
  always #25 mclk = ~mclk;
  cbig_top i_cbig_top (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .events, .group_tx_done_flag(gtx),
    .group_rx_flag(grx), .tx_int_req(txr), .rx_int_req(rxr), .irq);
  cbig_engine_model i_cbig_engine_model (.mclk, .start, .events);
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xf(0, a, CBIG_ZERO32);
    chk(q, e);
  endtask
  task ev(input cbig_events_t e, input logic et, input logic er);
    @(posedge mclk);
    start <= e;
    @(posedge mclk);
    start <= '0;
    @(negedge mclk);
    chk(txr, et);
    chk(rxr, er);
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1;
    xf(1, CBIG_OFF_TXIE, 32'h0000_00FF);
    rd(CBIG_OFF_TXIE, CBIG_ZERO32);
    // mode 3 is not enhanced; loop ends in mode 1
    for (int m = 3; m > 0; m--) begin
      xf(1, CBIG_OFF_MODE, m);
      xf(1, CBIG_OFF_TXIE, 32'h0000_00FF);
      rd(CBIG_OFF_TXIE, (m < 3) ? 32'h0000_001C : CBIG_ZERO32);
      xf(1, CBIG_OFF_BIE, 32'h0000_00FF);
      rd(CBIG_OFF_BIE, (m < 3) ? 32'h0000_00FF : CBIG_ZERO32);
    end
    rd(12'h100, CBIG_ZERO32);
    xf(1, CBIG_OFF_IEN, 32'h0000_0003);
    xf(1, CBIG_OFF_GRPEN, 32'h0000_0010);
    ev(11'h100, 1, 0);
    ev(11'h004, 0, 1);
    ev(11'h001, 0, 0);
    rd(CBIG_OFF_STAT, 32'h0000_0003);
    chk(gtx, 1);
    chk(grx, 1);
    chk(irq, 1);
    xf(1, CBIG_OFF_CLR, 32'h0000_0003);
    rd(CBIG_OFF_STAT, CBIG_ZERO32);
    chk(gtx, 0);
    chk(irq, 0);
    xf(1, CBIG_OFF_GRPEN, CBIG_ZERO32);
    ev(11'h7FF, 0, 0);
    rd(CBIG_OFF_STAT, 32'h0000_0001);
    xf(1, CBIG_OFF_GRPEN, 32'h0000_0012);
    xf(1, CBIG_OFF_TXIE, 32'h0000_0008);
    xf(1, CBIG_OFF_BIE, 32'h0000_0002);
    ev(11'h100, 0, 0);
    ev(11'h200, 1, 0);
    ev(11'h001, 0, 0);
    ev(11'h002, 0, 1);
    ev(11'h004, 0, 0);
    xf(1, CBIG_OFF_MODE, CBIG_ZERO32);
    rd(CBIG_OFF_BIE, CBIG_ZERO32);
    rstn <= 0;
    repeat (2) @(posedge mclk);
    rstn <= 1;
    rd(CBIG_OFF_STAT, CBIG_ZERO32);
    chk(irq, 0);
    close_out;
  end
endmodule
bind cbig_top cbig_checker i_cbig_checker (.mclk, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .events, .group_tx_done_flag,
  .group_rx_flag, .tx_int_req, .rx_int_req, .irq);
